// File: rtl/wstcm_top.sv
// Windowed service timer with clock monitor, APB slave
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
// How it works
// RQ1 - Earliest permitted service is 2048 instruction cycles into the window.
// RQ2 - Service bits 7:6 pick upper limit 8k, 16k, 32k or 64k cycles.
// RQ3 - Service bits 5:1 must carry key 01100; checked on every write.
// RQ4 - Service bit 0 enables the clock monitor.
// RQ5 - Timer runs only while option bit 2 is 0; pin then is fault output.
// RQ6 - Detectors idle in reset; leave reset with window 11 and monitor on.
// RQ7 - First matching write loads window and monitor, then locked till reset.
// RQ8 - Later writes must match bits 7:0; match restarts, mismatch faults.
// RQ9 - Timeout or too-early service raises the fault output.
// RQ10 - Fault drives pin low, holds 16 cycles after seen low, restarts on high.
// RQ11 - Service writes while the pin is low are ignored.
// RQ12 - Monitor holds pin low while clock slow, releases 16 cycles after.
// RQ13 - Never reject above 10 kHz, always reject below 10 Hz.
// RQ14 - Reads of the service register show zero in the key field.
// RQ15 - Window inhibited in halt and idle; clock monitor stays active.
// RQ16 - Halt exit resumes with RC and no delay, else restarts the window.
// RQ17 - Idle exit performs an automatic service restarting the window.
// RQ18 - Idle pending flag sets every 4096 cycles; software clears it.
// RQ19 - First service after reset is never early within the 64k window.
// RQ20 - Counters advance once per instruction-cycle enable pulse.
module wstcm_top #(
  parameter int INSTR_DIV_P = wstcm_pkg::INSTR_DIV,
  parameter int CM_GAP_P = wstcm_pkg::CM_GAP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic porN,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscInput,
  input wire logic faultOutNIn,
  output logic faultOutNOut,
  output logic faultOutNOe,
  output logic idleTimerPending
);
  import wstcm_pkg::*;

  typedef struct packed {
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [1:0] winSel;
    logic cmEn;
    logic armed;
    logic [16:0] winCnt;
    logic svcFault;
    logic seenLow;
    logic waitHigh;
    logic [5:0] holdCnt;
    logic cmBad;
    logic [5:0] cmCnt;
    logic [15:0] gapCnt;
    logic [7:0] divCnt;
    logic oscPrev;
    logic tick;
    logic [4:0] ctrl;
    logic pend;
    logic drive;
  } wstcm_state_t;

  typedef struct packed {
    logic [15:0] cnt;
  } wstcm_idle_t;

  wstcm_state_t st_reg;
  wstcm_state_t st_next;
  wstcm_idle_t idle_reg;
  wstcm_idle_t idle_next;

  // Upper limit decode, used by the timeout check
  function automatic logic [16:0] upperOf(input logic [1:0] sel);
    upperOf = UPPER_BASE << sel; // RQ2
  endfunction : upperOf

  logic setupPh;
  logic accessPh;
  logic svcWr;
  logic ctrlWr;
  logic statWr;
  logic wdEn;
  logic haltExit;
  logic idleExit;
  logic pinLow;
  logic keyOk;
  logic fullOk;
  logic early;
  logic timeout;
  logic pndSet;

  // Bus phase and write decode
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable & st_reg.rdy;
  assign svcWr = accessPh & pwrite & (paddr == SVC_OFFS);
  assign ctrlWr = accessPh & pwrite & (paddr == CTRL_OFFS);
  assign statWr = accessPh & pwrite & (paddr == STAT_OFFS);
  assign wdEn = ~st_reg.ctrl[WD_DIS_BIT]; // RQ5
  assign pinLow = ~faultOutNIn;
  // Low-power exits seen as falling edges of the mode bits
  assign haltExit = ctrlWr & st_reg.ctrl[HALT_BIT] & ~pwdata[HALT_BIT];
  assign idleExit = ctrlWr & st_reg.ctrl[IDLE_BIT] & ~pwdata[IDLE_BIT];
  // Service checks
  assign keyOk = (pwdata[KEY_HI:KEY_LO] == KEY_VAL); // RQ3
  assign fullOk = keyOk & (pwdata[SEL_HI:SEL_LO] == st_reg.winSel)
                  & (pwdata[CM_BIT] == st_reg.cmEn); // RQ8
  assign early = st_reg.armed & (st_reg.winCnt < LOWER_CYC); // RQ1 RQ19
  assign timeout = st_reg.winCnt >= upperOf(st_reg.winSel); // RQ9
  assign pndSet = st_reg.tick & (&idle_reg.cnt[IDLE_BIT_POS-1:0]); // RQ18

  // Next-state logic for everything on the main reset
  always_comb begin
    logic svcAct;
    logic winRun;
    svcAct = 1'b0;
    winRun = 1'b0;
    st_next = st_reg;
    st_next.tick = 1'b0;
    // APB: answer one cycle after setup, never stretched
    st_next.rdy = setupPh;
    if (setupPh) begin
      st_next.err = 1'b0;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        SVC_OFFS: begin
          // Key field hides the stored pattern
          st_next.rdata[SEL_HI:SEL_LO] = st_reg.winSel; // RQ14
          st_next.rdata[CM_BIT] = st_reg.cmEn;
        end
        CTRL_OFFS: st_next.rdata[4:0] = st_reg.ctrl;
        STAT_OFFS: begin
          st_next.rdata[PND_BIT] = st_reg.pend;
          st_next.rdata[PIN_BIT] = faultOutNIn;
          st_next.rdata[ARM_BIT] = st_reg.armed;
          st_next.rdata[CMBAD_BIT] = st_reg.cmBad;
          st_next.rdata[SVCF_BIT] = st_reg.svcFault;
        end
        default: st_next.err = 1'b1;
      endcase
    end
    if (ctrlWr) begin
      st_next.ctrl = pwdata[4:0];
    end
    // Instruction-cycle tick from oscillator rising edges
    st_next.oscPrev = oscInput;
    if (oscInput & ~st_reg.oscPrev) begin
      if (st_reg.divCnt == 8'(INSTR_DIV_P - 1)) begin
        st_next.divCnt = 8'h00;
        st_next.tick = 1'b1; // RQ20
      end else begin
        st_next.divCnt = st_reg.divCnt + 8'h01;
      end
    end
    // Clock monitor: edge gap counter, live in halt and idle too
    if (oscInput & ~st_reg.oscPrev) begin
      st_next.gapCnt = 16'h0000;
      st_next.cmBad = 1'b0;
    end else if (st_reg.gapCnt >= 16'(CM_GAP_P)) begin
      st_next.cmBad = st_reg.cmEn & wdEn; // RQ13 RQ15
    end else begin
      st_next.gapCnt = st_reg.gapCnt + 16'h0001;
    end
    // Release tail after the clock recovers
    if (st_reg.cmBad) begin
      st_next.cmCnt = HOLD_CYC; // RQ12
    end else if (st_reg.cmCnt != 6'h00 && st_reg.tick) begin
      st_next.cmCnt = st_reg.cmCnt - 6'h01;
    end
    // Window counting, frozen in halt, idle and while faulting
    winRun = wdEn & ~st_reg.ctrl[HALT_BIT] & ~st_reg.ctrl[IDLE_BIT]
             & ~st_reg.svcFault & ~st_reg.waitHigh; // RQ15
    if (winRun & st_reg.tick & ~timeout) begin
      st_next.winCnt = st_reg.winCnt + 17'h00001; // RQ20
    end
    if (winRun & timeout) begin
      st_next.svcFault = 1'b1; // RQ9
    end
    // Software service; ignored while the pin is low
    if (svcWr & wdEn & ~pinLow & ~st_reg.svcFault & ~st_reg.waitHigh) begin
      svcAct = 1'b1; // RQ11
    end
    if (svcAct) begin
      if (!st_reg.armed) begin
        if (keyOk) begin
          // One-time load, locked afterwards
          st_next.winSel = pwdata[SEL_HI:SEL_LO]; // RQ7
          st_next.cmEn = pwdata[CM_BIT]; // RQ4
          st_next.armed = 1'b1;
          st_next.winCnt = 17'h00000;
        end else begin
          st_next.svcFault = 1'b1; // RQ3
        end
      end else if (fullOk & ~early) begin
        st_next.winCnt = 17'h00000; // RQ8
      end else begin
        st_next.svcFault = 1'b1; // RQ8 RQ9
      end
    end
    // Halt exit: resume only for RC oscillator without wake delay
    if (haltExit & ~(st_reg.ctrl[RCOSC_BIT] & ~st_reg.ctrl[WDLY_BIT])) begin
      st_next.winCnt = 17'h00000; // RQ16
    end
    // Idle exit acts as a hardware service
    if (idleExit) begin
      st_next.winCnt = 17'h00000; // RQ17
    end
    // Fault hold: count only once the pin is seen low
    if (st_reg.svcFault) begin
      if (pinLow) begin
        st_next.seenLow = 1'b1;
      end
      if (st_reg.seenLow & st_reg.tick) begin
        st_next.holdCnt = st_reg.holdCnt + 6'h01;
      end
      if (st_reg.holdCnt >= HOLD_CYC) begin
        st_next.svcFault = 1'b0; // RQ10
        st_next.waitHigh = 1'b1;
        st_next.seenLow = 1'b0;
        st_next.holdCnt = 6'h00;
      end
    end
    // Window restarts when the pin has come back high
    if (st_reg.waitHigh & ~pinLow) begin
      st_next.waitHigh = 1'b0;
      st_next.winCnt = 17'h00000; // RQ10
    end
    // Pin driver: low for service fault or clock error
    st_next.drive = wdEn & (st_next.svcFault | st_next.cmBad
                    | (st_next.cmCnt != 6'h00)); // RQ5 RQ10 RQ12
    // Idle pending flag; a set beats a same-cycle clear
    if (statWr & pwdata[PND_BIT]) begin
      st_next.pend = 1'b0;
    end
    if (pndSet) begin
      st_next.pend = 1'b1; // RQ18
    end
  end

  // Idle timer keeps its count through the external reset
  always_comb begin
    idle_next = idle_reg;
    if (st_reg.tick) begin
      idle_next.cnt = idle_reg.cnt + 16'h0001;
    end
  end

  // Main state register; reset arms the window at its widest
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.winSel <= SEL_RST; // RQ6
      st_reg.cmEn <= CM_RST; // RQ6
      st_reg.ctrl <= CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Idle counter cleared only at power-on, not by rst_n
  always_ff @(posedge ref_clk or negedge porN) begin
    if (!porN) begin
      idle_reg <= '0;
    end else begin
      idle_reg <= idle_next; // RQ18
    end
  end

  // Outputs straight from flops
  assign prdata = st_reg.rdata;
  assign pready = st_reg.rdy;
  assign pslverr = st_reg.err & st_reg.rdy;
  assign faultOutNOe = st_reg.drive;
  assign faultOutNOut = st_reg.drive & 1'b0;
  assign idleTimerPending = st_reg.pend;

  // Checks on the design's own behaviour
  // Follows the bus data until armed, so the arming write itself is captured
  logic [1:0] lockedSel;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockedSel <= SEL_RST;
    end else if (!st_reg.armed) begin
      lockedSel <= pwdata[SEL_HI:SEL_LO];
    end
  end

  a_lock_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg.armed |-> st_reg.winSel == lockedSel) // RQ7
    else $error("window selection changed after first service");
  a_early_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
    svcWr & wdEn & st_reg.armed & early & ~pinLow & ~st_reg.svcFault
    & ~st_reg.waitHigh |=> st_reg.svcFault) // RQ1
    else $error("early service did not fault");
  a_first_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
    svcWr & wdEn & ~st_reg.armed & keyOk & ~pinLow & ~st_reg.svcFault
    & ~st_reg.waitHigh |=> st_reg.armed & ~st_reg.svcFault
    & st_reg.winCnt == 17'h00000) // RQ19
    else $error("first keyed service not accepted");
  a_key_bad: assert property (@(posedge ref_clk) disable iff (!rst_n)
    svcWr & wdEn & ~keyOk & ~pinLow & ~st_reg.svcFault & ~st_reg.waitHigh
    |=> st_reg.svcFault ##1 faultOutNOe) // RQ3
    else $error("bad key did not drive the pin");
  a_timeout: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wdEn & timeout & ~st_reg.ctrl[HALT_BIT] & ~st_reg.ctrl[IDLE_BIT]
    & ~st_reg.waitHigh & ~st_reg.svcFault |=> st_reg.svcFault) // RQ9
    else $error("window expiry did not fault");
  a_ignore_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    svcWr & pinLow
    |=> $stable(st_reg.winSel) & $stable(st_reg.armed) & ~$rose(st_reg.svcFault)) // RQ11
    else $error("service while pin low was acted on");
  a_read_key: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setupPh & paddr == SVC_OFFS
    |=> prdata[KEY_HI:KEY_LO] == 5'h00 & prdata[CM_BIT] == st_reg.cmEn) // RQ14
    else $error("key field visible on read");
  a_halt_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg.ctrl[HALT_BIT] & ~ctrlWr & ~svcWr & ~st_reg.waitHigh
    |=> $stable(st_reg.winCnt)) // RQ15
    else $error("window counted during halt");
  a_pend_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pndSet |=> idleTimerPending) // RQ18
    else $error("idle pending flag not set");
  a_cm_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg.cmBad & wdEn |-> faultOutNOe [*2]) // RQ12
    else $error("clock error not driving the pin");
  a_dis_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_reg.ctrl[WD_DIS_BIT] |=> ~faultOutNOe) // RQ5
    else $error("pin driven while timer disabled");
  a_reset_arm: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> st_reg.winSel == SEL_RST & st_reg.cmEn
    & ~faultOutNOe) // RQ6
    else $error("reset state not armed at widest window");

  c_valid_svc: cover property (@(posedge ref_clk) disable iff (!rst_n)
    svcWr & st_reg.armed & fullOk & ~early & ~pinLow);
  c_svc_fault: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(st_reg.svcFault) ##[1:20] ~st_reg.waitHigh);
  c_cm_fault: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(st_reg.cmBad));
  c_idle_exit: cover property (@(posedge ref_clk) disable iff (!rst_n)
    idleExit);
endmodule : wstcm_top

// File: rtl/wstcm_pkg.sv
// Constants for the windowed service timer and clock monitor
package wstcm_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] SVC_OFFS = 8'h00;
  localparam logic [7:0] CTRL_OFFS = 8'h04;
  localparam logic [7:0] STAT_OFFS = 8'h08;
  // Service register fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int KEY_HI = 5;
  localparam int KEY_LO = 1;
  localparam int CM_BIT = 0;
  localparam logic [4:0] KEY_VAL = 5'h0C;
  localparam logic [1:0] SEL_RST = 2'h3;
  localparam logic CM_RST = 1'b1;
  // Control register fields
  localparam int HALT_BIT = 0;
  localparam int IDLE_BIT = 1;
  localparam int WD_DIS_BIT = 2;
  localparam int RCOSC_BIT = 3;
  localparam int WDLY_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // Status register fields
  localparam int PND_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int ARM_BIT = 2;
  localparam int CMBAD_BIT = 3;
  localparam int SVCF_BIT = 4;
  // Window limits in instruction cycles
  localparam logic [16:0] LOWER_CYC = 17'h00800;
  localparam logic [16:0] UPPER_BASE = 17'h02000;
  // Fault hold after pin is seen low, instruction cycles
  localparam logic [5:0] HOLD_CYC = 6'h10;
  // Idle timer pending sets each time this counter bit toggles
  localparam int IDLE_BIT_POS = 12;
  // Oscillator edges per instruction cycle
  localparam int INSTR_DIV = 10;
  // Clock monitor: longest gap between oscillator edges
  localparam int CLK_PERIOD_NS = 10;
  localparam int CM_GAP_NS = 100000;
  localparam int CM_GAP_CYC = CM_GAP_NS / CLK_PERIOD_NS;
endpackage : wstcm_pkg

// File: verif/wstcm_pin_model.sv
// Far-side model: fault pin with weak pull-up, and the oscillator source
`timescale 1ns/10ps
module wstcm_pin_model (
  input wire logic ref_clk,
  input wire logic oscRun,
  input wire logic faultOutNOut,
  input wire logic faultOutNOe,
  output logic faultOutNIn,
  output logic oscInput
);
  // Pull-up holds the wire high unless the device pulls it low
  assign faultOutNIn = faultOutNOe ? faultOutNOut : 1'b1;

  // Oscillator toggles each clock while running; a stalled one stays flat
  initial oscInput = 1'b0;
  always @(posedge ref_clk) begin
    if (oscRun) begin
      oscInput <= ~oscInput;
    end
  end
endmodule : wstcm_pin_model

// File: verif/wstcm_top_tb.sv
// Self-checking bench for the service timer and clock monitor
`timescale 1ns/10ps
module wstcm_top_tb;
  import wstcm_pkg::*;
  localparam int DIV = 2;
  localparam int GAP = 50;
  localparam int TICK = 4; // Oscillator period 2 clocks, divided by DIV
  localparam int LOW = 2048 * TICK + 40; // Safely past the lower limit
  localparam logic [31:0] GOOD = 32'h18; // Window 00, key, monitor off
  logic ref_clk, rst_n, porN, psel, penable, pwrite, pready, pslverr, oscRun;
  logic oscInput, faultOutNIn, faultOutNOut, faultOutNOe, idleTimerPending, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;
  int t0;

  wstcm_top #(.INSTR_DIV_P(DIV), .CM_GAP_P(GAP)) u_wstcm_top (.ref_clk, .rst_n, .porN,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscInput,
    .faultOutNIn, .faultOutNOut, .faultOutNOe, .idleTimerPending);
  wstcm_pin_model u_wstcm_pin_model (.ref_clk, .oscRun, .faultOutNOut, .faultOutNOe,
    .faultOutNIn, .oscInput);

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Cycle count; a hang ends the run as a failure
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      failCount++;
      finalReport();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check({31'h0, pready}, 32'h1, "pready");
  endtask : apb

  // Bounded wait for the fault drive to reach a level
  task automatic waitOe(input logic lvl, input int lim, input string what);
    int n;
    n = 0;
    while (faultOutNOe !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, faultOutNOe}, {31'h0, lvl}, what);
  endtask : waitOe

  // Service fault: pin held 16 to 32 ticks, optional write while it is low
  task automatic faultPulse(input logic poke, input string what);
    waitOe(1'b1, 30, what);
    t0 = cycles;
    if (poke) begin
      apb(1'b1, SVC_OFFS, 32'h0);
    end
    waitOe(1'b0, 40 * TICK, what);
    check({31'h0, (cycles - t0 >= 16 * TICK) && (cycles - t0 <= 32 * TICK + 8)}, 1, what);
  endtask : faultPulse

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    porN <= 1'b1;
  endtask : doReset

  task automatic testReset();
    apb(1'b0, SVC_OFFS, 32'h0);
    check(rdata, {24'h0, SEL_RST, 5'h00, CM_RST}, "service reset");
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask : testReset

  // First service lands at once, then a second one comes too early
  task automatic testFirstEarly();
    apb(1'b1, SVC_OFFS, GOOD);
    idle(20);
    check({31'h0, faultOutNOe}, 32'h0, "first service");
    apb(1'b0, SVC_OFFS, 32'h0);
    check(rdata, 32'h0, "settings loaded");
    apb(1'b1, SVC_OFFS, GOOD);
    faultPulse(1'b1, "early service");
    idle(20);
    check({31'h0, faultOutNOe}, 32'h0, "write while low ignored");
    $display("test first and early done");
  endtask : testFirstEarly

  // In-window service passes; each mismatched field faults
  task automatic testMatch();
    logic [31:0] bad [3];
    bad = '{32'hD8, 32'h1A, 32'h19};
    idle(LOW);
    apb(1'b1, SVC_OFFS, GOOD);
    idle(20);
    check({31'h0, faultOutNOe}, 32'h0, "valid service");
    foreach (bad[i]) begin
      idle(LOW);
      apb(1'b1, SVC_OFFS, bad[i]);
      faultPulse(1'b0, "mismatch");
    end
    $display("test match done");
  endtask : testMatch

  task automatic testTimeout();
    idle(8192 * TICK - 64);
    check({31'h0, faultOutNOe}, 32'h0, "no early timeout");
    waitOe(1'b1, 200, "timeout");
    check({31'h0, idleTimerPending}, 32'h1, "pending set");
    apb(1'b1, STAT_OFFS, 32'h1);
    idle(2);
    check({31'h0, idleTimerPending}, 32'h0, "pending cleared");
    waitOe(1'b0, 200, "timeout release");
    $display("test timeout done");
  endtask : testTimeout

  // Idle exit services by itself; a disabled timer ignores bad writes
  task automatic testModes();
    idle(LOW);
    apb(1'b1, CTRL_OFFS, 32'h2);
    apb(1'b1, CTRL_OFFS, 32'h0);
    apb(1'b1, SVC_OFFS, GOOD);
    faultPulse(1'b0, "idle exit");
    idle(LOW);
    apb(1'b1, CTRL_OFFS, 32'h1);
    apb(1'b1, CTRL_OFFS, 32'h0);
    apb(1'b1, SVC_OFFS, GOOD);
    faultPulse(1'b0, "halt exit");
    apb(1'b1, CTRL_OFFS, 32'h4);
    apb(1'b1, SVC_OFFS, 32'h0);
    idle(20);
    check({31'h0, faultOutNOe}, 32'h0, "timer disabled");
    $display("test modes done");
  endtask : testModes

  // Monitor is on out of reset, off after the first service says so
  task automatic testMonitor();
    doReset();
    oscRun <= 1'b0;
    waitOe(1'b1, GAP + 40, "clock lost");
    idle(200);
    check({31'h0, faultOutNOe}, 32'h1, "clock still lost");
    oscRun <= 1'b1;
    t0 = cycles;
    waitOe(1'b0, 40 * TICK, "clock back");
    check({31'h0, (cycles - t0 >= 16 * TICK) && (cycles - t0 <= 32 * TICK + 16)}, 1,
      "recovery delay");
    apb(1'b1, SVC_OFFS, GOOD);
    oscRun <= 1'b0;
    idle(GAP + 40);
    check({31'h0, faultOutNOe}, 32'h0, "monitor off");
    oscRun <= 1'b1;
    $display("test monitor done");
  endtask : testMonitor

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finalReport

  // Main sequence
  initial begin
    rst_n = 1'b0;
    porN = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    oscRun = 1'b1;
    doReset();
    testReset();
    testFirstEarly();
    testMatch();
    testTimeout();
    testModes();
    testMonitor();
    finalReport();
  end
endmodule : wstcm_top_tb
